/* hdl/apr_regs.sv */
// Purpose: apb register bank for audio control and packet buffers
// Assumes: apb slave, zero wait states, pready one cycle after setup
// Notes:   packet words are read out by the inserter side port
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

// Notes on behaviour
// - audio packets go out only while control bit 0 is set.
// - sample collector uses the 3-bit active channel count.
// - payload bytes renumbered from zero, packed little endian per word.
// - wrong write counts or order are not detected; contents undefined.
// - 24-bit m value readable and writable.
// - 24-bit n value readable and writable.
// - m and n are taken as given for synchronous clocks.
// - extension packet is a fixed 36-byte payload.
// - one extension packet stored; a new one replaces it.
// - extension payload words packed little endian, bytes 0..35.
module apr_regs (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic AUDIO_ENABLE_O,
    output logic [2:0] CHANNEL_COUNT_O,
    output logic [23:0] M_VALUE_O,
    output logic [23:0] N_VALUE_O,
    output logic INFO_VALID_O,
    output logic EXT_VALID_O,
    input wire logic [4:0] PKT_RADDR_I,
    output logic [31:0] PKT_RDATA_O
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    apr_pkg::apr_apb_req_type req;
    apr_pkg::apr_cfg_type cfg_ff, nxt_cfg;
    apr_pkg::apr_state_type st_ff, nxt_st;
    logic [3:0] info_idx_ff, nxt_info_idx;
    logic [3:0] ext_idx_ff, nxt_ext_idx;
    logic info_valid_ff, nxt_info_valid;
    logic ext_valid_ff, nxt_ext_valid;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;
    logic setup, access, wr, known;
    logic mem_we;
    logic [4:0] mem_waddr;

    assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I,
                   addr: PADDR_I, wdata: PWDATA_I};
    assign setup = req.sel && !req.enable && st_ff == apr_pkg::APR_IDLE;
    // writes land at the edge that completes the access phase
    assign access = req.sel && req.enable && st_ff == apr_pkg::APR_DONE;
    assign wr = access && req.write;
    always_comb begin
        known = 1'b0;
        if (req.addr == `APR_OFF_CTRL || req.addr == `APR_OFF_CHAN ||
            req.addr == `APR_OFF_INFO || req.addr == `APR_OFF_MVAL ||
            req.addr == `APR_OFF_NVAL || req.addr == `APR_OFF_STAT) begin
            known = 1'b1;
        end
        if (req.addr >= `APR_OFF_EXT_LO && req.addr <= `APR_OFF_EXT_HI &&
            req.addr[1:0] == 2'h0) begin
            known = 1'b1;
        end
    end

    // ----------------------------------------
    // handshake: answer in the access cycle
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            apr_pkg::APR_IDLE: begin
                if (setup) begin
                    nxt_st = apr_pkg::APR_DONE;
                end
            end
            apr_pkg::APR_DONE: begin
                nxt_st = apr_pkg::APR_IDLE;
            end
            default: begin
                nxt_st = apr_pkg::APR_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // register file and packet indices
    // ----------------------------------------
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_info_idx = info_idx_ff;
        nxt_ext_idx = ext_idx_ff;
        nxt_info_valid = info_valid_ff;
        nxt_ext_valid = ext_valid_ff;
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        mem_we = 1'b0;
        mem_waddr = 5'h00;
        if (setup) begin
            nxt_pslverr = !known;
        end
        if (wr && known) begin
            if (req.addr == `APR_OFF_CTRL) begin
                nxt_cfg.audio_enable = req.wdata[`APR_ENABLE_BIT];
            end
            if (req.addr == `APR_OFF_CHAN) begin
                nxt_cfg.channel_count = req.wdata[2:0];
            end
            if (req.addr == `APR_OFF_MVAL) begin
                nxt_cfg.m_value = req.wdata[23:0];
            end
            if (req.addr == `APR_OFF_NVAL) begin
                nxt_cfg.n_value = req.wdata[23:0];
            end
            if (req.addr == `APR_OFF_INFO) begin
                // word lands whole; byte order is software's
                mem_we = 1'b1;
                mem_waddr = {1'b0, info_idx_ff};
                nxt_info_valid = 1'b0;
                if (info_idx_ff == `APR_INFO_WORDS - 4'h1) begin
                    nxt_info_idx = 4'h0;
                    nxt_info_valid = 1'b1;
                end else begin
                    nxt_info_idx = info_idx_ff + 4'h1;
                end
            end
            if (req.addr >= `APR_OFF_EXT_LO &&
                req.addr <= `APR_OFF_EXT_HI) begin
                // single buffer, overwritten in place
                mem_we = 1'b1;
                mem_waddr = 5'(`APR_INFO_WORDS) + {1'b0, ext_idx_ff};
                nxt_ext_valid = 1'b0;
                if (ext_idx_ff == `APR_EXT_WORDS - 4'h1) begin
                    nxt_ext_idx = 4'h0;
                    nxt_ext_valid = 1'b1;
                end else begin
                    nxt_ext_idx = ext_idx_ff + 4'h1;
                end
            end
        end
        if (setup && !req.write && known) begin
            // write-only ports fall through and read zero
            if (req.addr == `APR_OFF_CTRL) begin
                nxt_prdata = {31'h0000_0000, cfg_ff.audio_enable};
            end
            if (req.addr == `APR_OFF_CHAN) begin
                nxt_prdata = {29'h0000_0000, cfg_ff.channel_count};
            end
            if (req.addr == `APR_OFF_MVAL) begin
                nxt_prdata = {8'h00, cfg_ff.m_value};
            end
            if (req.addr == `APR_OFF_NVAL) begin
                nxt_prdata = {8'h00, cfg_ff.n_value};
            end
            if (req.addr == `APR_OFF_STAT) begin
                nxt_prdata = {22'h00_0000, ext_idx_ff, info_idx_ff,
                              ext_valid_ff, info_valid_ff};
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            st_ff <= apr_pkg::APR_IDLE;
            cfg_ff <= '{audio_enable: `APR_RST_CTRL,
                        channel_count: `APR_RST_CHAN,
                        m_value: `APR_RST_MN, n_value: `APR_RST_MN};
            info_idx_ff <= 4'h0;
            ext_idx_ff <= 4'h0;
            info_valid_ff <= 1'b0;
            ext_valid_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
            info_idx_ff <= nxt_info_idx;
            ext_idx_ff <= nxt_ext_idx;
            info_valid_ff <= nxt_info_valid;
            ext_valid_ff <= nxt_ext_valid;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ----------------------------------------
    // packet store
    // ----------------------------------------
    apr_pkt_mem u_mem (
        .clk_i(REF_CLK_I),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(req.wdata),
        .raddr_i(PKT_RADDR_I),
        .rdata_o(PKT_RDATA_O)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign PRDATA_O = prdata_ff;
    // one-hot done bit, straight from the state flop
    assign PREADY_O = st_ff[1];
    assign PSLVERR_O = pslverr_ff;
    assign AUDIO_ENABLE_O = cfg_ff.audio_enable;
    assign CHANNEL_COUNT_O = cfg_ff.channel_count;
    assign M_VALUE_O = cfg_ff.m_value;
    assign N_VALUE_O = cfg_ff.n_value;
    assign INFO_VALID_O = info_valid_ff;
    assign EXT_VALID_O = ext_valid_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_ctrl_wr;
        wr && req.addr == `APR_OFF_CTRL;
    endsequence

    sequence s_info_word;
        wr && req.addr == `APR_OFF_INFO;
    endsequence

    // any aligned word of the window advances the same index
    sequence s_ext_word;
        wr && known && req.addr >= `APR_OFF_EXT_LO &&
        req.addr <= `APR_OFF_EXT_HI;
    endsequence

    a_enable_follows: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_ctrl_wr |=>
        AUDIO_ENABLE_O == $past(PWDATA_I[0]))
        else $error("enable not stored");
    a_chan_follows: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        wr && req.addr == `APR_OFF_CHAN |=>
        CHANNEL_COUNT_O == $past(PWDATA_I[2:0]))
        else $error("channel count not stored");
    a_m_stored: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        wr && req.addr == `APR_OFF_MVAL |=>
        M_VALUE_O == $past(PWDATA_I[23:0]))
        else $error("m value not stored");
    a_n_stored: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        wr && req.addr == `APR_OFF_NVAL |=>
        N_VALUE_O == $past(PWDATA_I[23:0]))
        else $error("n value not stored");
    a_m_readback: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        setup && !req.write && req.addr == `APR_OFF_MVAL |=>
        PREADY_O && PRDATA_O == {8'h00, M_VALUE_O})
        else $error("m value readback wrong");
    a_n_readback: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        setup && !req.write && req.addr == `APR_OFF_NVAL |=>
        PRDATA_O == {8'h00, N_VALUE_O})
        else $error("n value readback wrong");
    a_wo_reads_zero: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        setup && !req.write && (req.addr == `APR_OFF_INFO ||
        req.addr == `APR_OFF_EXT_LO) |=> PRDATA_O == 32'h0000_0000)
        else $error("write-only port read nonzero");
    a_info_wraps: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_info_word ##0 (info_idx_ff == 4'h7) |=>
        info_idx_ff == 4'h0 && INFO_VALID_O)
        else $error("info index wrap wrong");
    a_info_steps: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_info_word ##0 (info_idx_ff != 4'h7) |=>
        info_idx_ff == $past(info_idx_ff) + 4'h1 && !INFO_VALID_O)
        else $error("info index step wrong");
    a_ext_wraps: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_ext_word ##0 (ext_idx_ff == 4'h8) |=>
        ext_idx_ff == 4'h0 && EXT_VALID_O)
        else $error("ext index wrap wrong");
    a_ext_steps: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_ext_word ##0 (ext_idx_ff != 4'h8) |=>
        ext_idx_ff == $past(ext_idx_ff) + 4'h1 && !EXT_VALID_O)
        else $error("ext index step wrong");
    a_ext_replaces: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_ext_word ##0 (ext_idx_ff == 4'h0) |=>
        !EXT_VALID_O && ext_idx_ff == 4'h1)
        else $error("ext packet not restarted");
    a_ready_once: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        PREADY_O |=>
        !PREADY_O)
        else $error("ready held");
endmodule : apr_regs

`default_nettype wire

/* hdl/apr_params.svh */
// Purpose: constants for the audio packet register bank
// Assumes: byte addresses on a 32-bit apb bus
// Notes:   included by its bare name
`ifndef APR_PARAMS_SVH
`define APR_PARAMS_SVH

`define APR_ADDR_W 12
`define APR_OFF_CTRL 12'h300
`define APR_OFF_CHAN 12'h304
`define APR_OFF_INFO 12'h308
`define APR_OFF_MVAL 12'h328
`define APR_OFF_NVAL 12'h32c
`define APR_OFF_EXT_LO 12'h330
`define APR_OFF_EXT_HI 12'h350
`define APR_OFF_STAT 12'h354
`define APR_INFO_WORDS 4'h8
`define APR_EXT_WORDS 4'h9
`define APR_ENABLE_BIT 0
`define APR_CHAN_W 3
`define APR_MN_W 24
`define APR_RST_CTRL 1'h0
`define APR_RST_CHAN 3'h0
`define APR_RST_MN 24'h00_0000

`endif

/* hdl/apr_pkg.sv */
// Purpose: shared types of the audio packet register bank
// Assumes: nothing
// Notes:   constants live in apr_params.svh
package apr_pkg;

    typedef struct packed {
        logic       sel;
        logic       enable;
        logic       write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apr_apb_req_type;

    typedef struct packed {
        logic       audio_enable;
        logic [2:0] channel_count;
        logic [23:0] m_value;
        logic [23:0] n_value;
    } apr_cfg_type;

    typedef enum logic [1:0] {
        APR_IDLE = 2'b01,
        APR_DONE = 2'b10
    } apr_state_type;

endpackage : apr_pkg

/* hdl/apr_pkt_mem.sv */
// Purpose: packet word store, registered read port
// Assumes: one write and one read port, same clock
// Notes:   holds info frame words 0..7 and extension words 8..16
`timescale 1ns/1ps
`default_nettype none

module apr_pkt_mem (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [4:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [4:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:16];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : apr_pkt_mem

`default_nettype wire

/* bench/apr_regs_test.sv */
// Purpose: self-checking bench for the audio packet register bank
// Assumes: apb answer comes in the access phase; store read one cycle late
// Notes:   fixed stimulus only
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_regs_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [4:0] praddr = 5'h00;
    logic [31:0] prdata, pkt_rdata;
    logic pready, pslverr, aud_en, info_vld, ext_vld;
    logic [2:0] chan;
    logic [23:0] m_val, n_val;
    int num_errors = 0;
    int compares = 0;

    always #2 clk = ~clk;

    apr_regs dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .AUDIO_ENABLE_O(aud_en),
        .CHANNEL_COUNT_O(chan), .M_VALUE_O(m_val), .N_VALUE_O(n_val),
        .INFO_VALID_O(info_vld), .EXT_VALID_O(ext_vld),
        .PKT_RADDR_I(praddr), .PKT_RDATA_O(pkt_rdata));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h0000_0001, 32'h0000_0000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk("write_err", 32'h0000_0000, {31'h0, err});
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk("read_err", 32'h0000_0000, {31'h0, err});
        chk(what, exp, rd);
    endtask : rd_chk

    task automatic pkt_chk(input logic [4:0] idx, input logic [31:0] exp);
        praddr <= idx;
        @(posedge clk);
        @(posedge clk);
        chk("pkt_word", exp, pkt_rdata);
    endtask : pkt_chk

    // four consecutive bytes, lowest in the low lane
    function automatic logic [31:0] lw(input logic [7:0] b);
        return {b + 8'h03, b + 8'h02, b + 8'h01, b};
    endfunction : lw

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_ctrl;
        rd_chk("m_reset", `APR_OFF_MVAL, 32'h0000_0000);
        rd_chk("n_reset", `APR_OFF_NVAL, 32'h0000_0000);
        wr(`APR_OFF_CTRL, 32'h0000_0001);
        chk("enable_on", 32'h0000_0001, {31'h0, aud_en});
        wr(`APR_OFF_CTRL, 32'hFFFF_FFFE);
        chk("enable_off", 32'h0000_0000, {31'h0, aud_en});
        wr(`APR_OFF_CHAN, 32'hFFFF_FFFF);
        chk("chan_out", 32'h0000_0007, {29'h0, chan});
        rd_chk("chan_rd", `APR_OFF_CHAN, 32'h0000_0007);
        wr(`APR_OFF_MVAL, 32'hFFFF_FFFF);
        chk("m_out", 32'h00FF_FFFF, {8'h00, m_val});
        rd_chk("m_rd", `APR_OFF_MVAL, 32'h00FF_FFFF);
        wr(`APR_OFF_NVAL, 32'h12A5_5A5A);
        chk("n_out", 32'h00A5_5A5A, {8'h00, n_val});
        rd_chk("n_rd", `APR_OFF_NVAL, 32'h00A5_5A5A);
    endtask : t_ctrl

    task automatic t_info;
        for (int i = 0; i < 8; i++) begin
            wr(`APR_OFF_INFO, lw(8'(4 * i)));
            if (i == 6) chk("info_part", 32'h0, {31'h0, info_vld});
        end
        chk("info_valid", 32'h0000_0001, {31'h0, info_vld});
        for (int i = 0; i < 8; i++) pkt_chk(5'(i), lw(8'(4 * i)));
        rd_chk("info_port", `APR_OFF_INFO, 32'h0000_0000);
        rd_chk("st_info", `APR_OFF_STAT, 32'h0000_0001);
    endtask : t_info

    task automatic t_ext(input logic [7:0] base);
        for (int i = 0; i < 9; i++) begin
            wr(`APR_OFF_EXT_LO + 12'(4 * i), lw(base + 8'(4 * i)));
            if (i == 7) chk("ext_part", 32'h0, {31'h0, ext_vld});
            if (i == 7) rd_chk("st_mid", `APR_OFF_STAT, 32'h0000_0201);
        end
        chk("ext_valid", 32'h0000_0001, {31'h0, ext_vld});
        for (int i = 0; i < 9; i++) begin
            pkt_chk(5'(8 + i), lw(base + 8'(4 * i)));
        end
        rd_chk("ext_port", `APR_OFF_EXT_HI, 32'h0000_0000);
        rd_chk("st_ext", `APR_OFF_STAT, 32'h0000_0003);
    endtask : t_ext

    task automatic t_unmapped;
        logic [31:0] rd;
        logic err;
        apb(1'b1, 12'h400, 32'h0000_0000, rd, err);
        chk("unmapped_err", 32'h0000_0001, {31'h0, err});
        apb(1'b0, 12'h400, 32'h0000_0000, rd, err);
        chk("unmapped_err", 32'h0000_0001, {31'h0, err});
        chk("unmapped_data", 32'h0000_0000, rd);
        chk("chan_kept", 32'h0000_0007, {29'h0, chan});
    endtask : t_unmapped

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("enable_rst", 32'h0000_0000, {31'h0, aud_en});
        t_ctrl();
        t_info();
        t_ext(8'h40);
        t_ext(8'h80);
        t_unmapped();
        report_and_stop();
    end

    initial begin
        #40000;
        num_errors++;
        report_and_stop();
    end
endmodule : apr_regs_test
`default_nettype wire
